// *** bench/bcr_conv_model.sv ***
// Converter-side model answering transition starts
`timescale 1ns/1ps
module bcr_conv_model #(parameter int DLY = 5) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic transition_start,
   output logic in_regulation,
   output logic transition_done
);
   int cnt_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) cnt_reg <= 0;
      else if (transition_start) cnt_reg <= DLY;
      else if (cnt_reg > 0) cnt_reg <= cnt_reg - 1;
   end
   // Out of regulation while the output is moving
   assign in_regulation = (cnt_reg == 0);
   assign transition_done = (cnt_reg == 1);
endmodule

// *** bench/bcr_sva.sv ***
// Port checker for the regulator control bank
`timescale 1ns/1ps
module bcr_sva (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic on_pin,
   input wire logic in_regulation,
   input wire logic run,
   input wire logic pfm_allowed,
   input wire logic off_pulldown,
   input wire logic [2:0] rise_slew_code,
   input wire logic single_step,
   input wire logic transition_start
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ----
   // Helpers
   // ----
   // Read data is valid only after a clean enabled cycle
   logic rd_ok_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) rd_ok_reg <= 1'b0;
      else rd_ok_reg <= ce;
   end
   sequence en_wr(v);
      ce && reg_wr && reg_addr < 8'h02 && reg_wdata[7] == v;
   endsequence
   sequence quiet;
      ce && !reg_wr && on_pin;
   endsequence
   // ----
   // Properties
   // ----
   run_off_a: assert property (en_wr(1'b0) ##1 quiet |=> !run)
      else $error("run high after enable cleared");
   run_on_a: assert property (en_wr(1'b1) ##1 quiet |=> run)
      else $error("run low with enable and on pin");
   pin_off_a: assert property (ce && !on_pin |=> !run)
      else $error("run high with on pin low");
   pwm_force_a: assert property (
      ce && reg_wr && reg_addr == 8'h02 && reg_wdata[3:2] == 2'h2 ##1 quiet |=> !pfm_allowed)
      else $error("pfm allowed under forced pwm");
   supplier_rd_a: assert property (
      rd_ok_reg && $past(reg_addr) == 8'h02 |-> reg_rdata[7:6] == bcr_pkg::SUPPLIER_CODE)
      else $error("supplier code wrong");
   in_reg_rd_a: assert property (
      rd_ok_reg && $past(reg_addr) == 8'h03 |-> reg_rdata[5] == $past(in_regulation))
      else $error("regulation flag wrong");
   start_cause_a: assert property (
      transition_start |-> $past(reg_wr) && $past(reg_addr) == 8'h03 && $past(reg_wdata[7]))
      else $error("start without trigger write");
   pulldown_a: assert property (off_pulldown |-> !run)
      else $error("pulldown while running");
   slew_step_a: assert property (single_step == (rise_slew_code == 3'h7))
      else $error("single step mismatch");
endmodule
bind bcr_regs bcr_sva chk (.clk, .nrst, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .on_pin,
   .in_regulation, .run, .pfm_allowed, .off_pulldown, .rise_slew_code, .single_step, .transition_start);

// *** bench/tb_top.sv ***
// Self-checking bench for the regulator control bank
`timescale 1ns/1ps
module tb_top;
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic on_pin = 1'b1;
   logic volt_pick_pin = 1'b1;
   logic [7:0] reg_rdata;
   logic run, pfm_allowed, off_pulldown, single_step, transition_start, in_regulation, transition_done;
   logic [5:0] target_code;
   logic [2:0] rise_slew_code;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   bcr_regs dut (.clk, .nrst, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .on_pin, .volt_pick_pin,
      .in_regulation, .transition_done, .run, .target_code, .pfm_allowed, .off_pulldown, .rise_slew_code,
      .single_step, .transition_start);
   bcr_conv_model conv (.clk, .nrst, .transition_start, .in_regulation, .transition_done);
   // ----
   // Clock, watchdog and bus tasks
   // ----
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   // Derived outputs trail the stored register by one edge
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h00, 8'hD8);
      rd(8'h01, 8'hE4);
      rd(8'h02, 8'h70);
      rd(8'h03, 8'h67);
      rd(8'h04, 8'h00);
      `CHK("target_code", 6'h24, target_code)
      wr(8'h02, 8'hFF);
      rd(8'h02, 8'h7F);
      `CHK("pfm_allowed", 1'b1, pfm_allowed)
      for (int m = 0; m < 4; m++) begin
         wr(8'h02, 8'h10 | 8'(m << 2));
         settle();
         `CHK("pfm_allowed", 1'(m % 2), pfm_allowed)
      end
      wr(8'h02, 8'h12);
      settle();
      `CHK("pfm_allowed", 1'b1, pfm_allowed)
      wr(8'h02, 8'h10);
      volt_pick_pin <= 1'b0;
      settle();
      `CHK("pfm_allowed", 1'b1, pfm_allowed)
      `CHK("target_code", 6'h18, target_code)
      wr(8'h00, 8'h58);
      rd(8'h01, 8'h64);
      `CHK("run", 1'b0, run)
      wr(8'h01, 8'hE4);
      rd(8'h00, 8'hD8);
      `CHK("run", 1'b1, run)
      @(posedge clk);
      on_pin <= 1'b0;
      settle();
      `CHK("run", 1'b0, run)
      `CHK("off_pulldown", 1'b1, off_pulldown)
      wr(8'h03, 8'h07);
      settle();
      `CHK("off_pulldown", 1'b0, off_pulldown)
      @(posedge clk);
      on_pin <= 1'b1;
      wr(8'h03, 8'h87);
      rd(8'h03, 8'h27);
      wr(8'h02, 8'h00);
      settle();
      `CHK("target_code", 6'h24, target_code)
      wr(8'h03, 8'h87);
      #1;
      `CHK("transition_start", 1'b1, transition_start)
      rd(8'h03, 8'h87);
      repeat (8) @(posedge clk);
      rd(8'h03, 8'h27);
      for (int i = 0; i < 8; i++) begin
         wr(8'h03, 8'(i));
         settle();
         `CHK("rise_slew_code", 3'(i), rise_slew_code)
         `CHK("single_step", 1'(i == 7), single_step)
      end
      // Clock enable low must drop the write
      @(posedge clk);
      ce <= 1'b0;
      wr(8'h03, 8'h40);
      @(posedge clk);
      ce <= 1'b1;
      rd(8'h03, 8'h27);
      summarize();
   end
endmodule

// *** design/bcr_pkg.sv ***
// Package with register map, field positions and reset values for the regulator control bank
package bcr_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_VOLTAGE_SETTING_A = 8'h00;
   localparam logic [7:0] ADDR_VOLTAGE_SETTING_B = 8'h01;
   localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'h02;
   localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h03;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ENABLE_BIT = 7;
   localparam int SPARE_BIT = 6;
   localparam int PIN_SELECT_BIT = 4;
   localparam int MODE_LSB = 2;
   localparam int REG_B_PFM_BIT = 1;
   localparam int LOW_PICK_PFM_BIT = 0;
   localparam int TRIGGER_BIT = 7;
   localparam int PULLDOWN_BIT = 6;
   localparam int IN_REG_BIT = 5;
   // ----------------------------------------
   // Reset values and fixed field codes
   // ----------------------------------------
   localparam logic RST_ENABLE = 1'h1;
   localparam logic RST_SPARE = 1'h1;
   localparam logic [5:0] RST_CODE_A = 6'h18;
   localparam logic [5:0] RST_CODE_B = 6'h24;
   // Supplier code value is arbitrary
   localparam logic [1:0] SUPPLIER_CODE = 2'h1;
   localparam logic RST_CFG_BIT5 = 1'h1;
   localparam logic RST_PIN_SELECT = 1'h1;
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic RST_REG_B_PFM = 1'h0;
   localparam logic RST_LOW_PICK_PFM = 1'h0;
   localparam logic RST_PULLDOWN = 1'h1;
   localparam logic [1:0] RST_CTL_SPARE = 2'h0;
   localparam logic [2:0] RST_SLEW = 3'h7;
   localparam logic [2:0] SLEW_SINGLE_STEP = 3'h7;
   localparam logic [1:0] MODE_FORCE_PWM = 2'h2;
   localparam logic [1:0] MODE_FOLLOW = 2'h0;
endpackage

// *** design/bcr_regs.sv ***
// Control and status register bank of the step-down regulator
//
// Contract
// [RL1] Enable bit 0 keeps converter shut down
// [RL2] One shared enable bit at both settings
// [RL3] Enable 1: on pin gates running
// [RL4] Low six bits hold voltage code
// [RL5] Config bits 7:6 read fixed supplier code
// [RL6] Pin select 0 uses setting B
// [RL7] Pin select 1: pick pin chooses setting
// [RL8] Pick pin low uses setting A
// [RL9] Mode policy 00 follows per-source bits
// [RL10] Policy 01/11 forces PFM with auto-PWM
// [RL11] Policy 10 forces PWM always
// [RL12] Setting B mode bit picks PWM/PFM
// [RL13] Low-pick mode bit ignored; always PFM
// [RL14] Trigger write starts transition when software-selected
// [RL15] Trigger ignored while pin select is 1
// [RL16] Trigger self-clears when transition completes
// [RL17] Discharge bit pulls output down when off
// [RL18] In-regulation flag reads regulation status
// [RL19] Slew codes 0-6 double rate each step
// [RL20] Slew code 7 uses single step
// [RL21] Read-only bits ignore writes
// [RL22] Disabled bits stored but ignored
// [RL23] Serial bus transfers MSB first
`timescale 1ns/1ps
module bcr_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Register port, byte already deserialised MSB first by the serial front end
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Pins and converter status
   input wire logic on_pin,
   input wire logic volt_pick_pin,
   input wire logic in_regulation,
   input wire logic transition_done,
   // Converter controls
   output logic run,
   output logic [5:0] target_code,
   output logic pfm_allowed,
   output logic off_pulldown,
   output logic [2:0] rise_slew_code,
   output logic single_step,
   output logic transition_start
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic regulator_enable_reg;
   logic spare_a_reg;
   logic spare_b_reg;
   logic [5:0] code_a_reg;
   logic [5:0] code_b_reg;
   logic cfg_bit5_reg;
   logic pin_select_ctl_reg;
   logic [1:0] mode_reg;
   logic reg_b_pfm_reg;
   logic low_pick_pfm_reg;
   logic trigger_reg;
   logic off_pulldown_reg;
   logic [1:0] ctl_spare_reg;
   logic [2:0] rise_slew_reg;
   logic [7:0] rdata_reg;
   logic run_reg;
   logic [5:0] target_reg;
   logic pfm_reg;
   logic pulldown_out_reg;
   logic start_reg;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire logic wr_a = ce && reg_wr && (reg_addr == bcr_pkg::ADDR_VOLTAGE_SETTING_A);
   wire logic wr_b = ce && reg_wr && (reg_addr == bcr_pkg::ADDR_VOLTAGE_SETTING_B);
   wire logic wr_cfg = ce && reg_wr && (reg_addr == bcr_pkg::ADDR_CONVERTER_CONFIG);
   wire logic wr_ctl = ce && reg_wr && (reg_addr == bcr_pkg::ADDR_CONVERTER_CONTROL);
   wire logic trigger_write = wr_ctl && reg_wdata[bcr_pkg::TRIGGER_BIT];
   // Software start only counts with pin selection off
   wire logic trigger_accept = trigger_write && !pin_select_ctl_reg; // [RL14] [RL15]
   wire logic use_b = !pin_select_ctl_reg || volt_pick_pin; // [RL6] [RL7] [RL8]
   wire logic running = regulator_enable_reg && on_pin; // [RL1] [RL3]
   wire logic enable_next = wr_b ? reg_wdata[bcr_pkg::ENABLE_BIT] : reg_wdata[bcr_pkg::ENABLE_BIT];
   // Low-pick bit is stored only; the low source is always PFM-capable
   wire logic source_pfm = use_b ? reg_b_pfm_reg : 1'b1; // [RL12] [RL13] [RL22]
   wire logic pfm_next = (mode_reg == bcr_pkg::MODE_FOLLOW) ? source_pfm : // [RL9]
      (mode_reg != bcr_pkg::MODE_FORCE_PWM); // [RL10] [RL11]
   // Set wins over the done-clear so a fresh start is never lost
   wire logic trigger_next = trigger_accept ? 1'b1 : (transition_done ? 1'b0 : trigger_reg); // [RL16]

   wire logic [7:0] rd_a = {regulator_enable_reg, spare_a_reg, code_a_reg}; // [RL2]
   wire logic [7:0] rd_b = {regulator_enable_reg, spare_b_reg, code_b_reg}; // [RL2]
   wire logic [7:0] rd_cfg = {bcr_pkg::SUPPLIER_CODE, cfg_bit5_reg, pin_select_ctl_reg, mode_reg,
      reg_b_pfm_reg, low_pick_pfm_reg}; // [RL5]
   // In-regulation bit is the live input; writes never reach it
   wire logic [7:0] rd_ctl = {trigger_reg, off_pulldown_reg, in_regulation, ctl_spare_reg,
      rise_slew_reg}; // [RL18] [RL21]
   // Bit 7 leads each byte so the serial front end shifts it out first
   wire logic [7:0] rd_mux = (reg_addr == bcr_pkg::ADDR_VOLTAGE_SETTING_A) ? rd_a : // [RL23]
      (reg_addr == bcr_pkg::ADDR_VOLTAGE_SETTING_B) ? rd_b :
      (reg_addr == bcr_pkg::ADDR_CONVERTER_CONFIG) ? rd_cfg :
      (reg_addr == bcr_pkg::ADDR_CONVERTER_CONTROL) ? rd_ctl : 8'h00;

   // ----------------------------------------
   // Setting registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regulator_enable_reg <= bcr_pkg::RST_ENABLE;
         spare_a_reg <= bcr_pkg::RST_SPARE;
         spare_b_reg <= bcr_pkg::RST_SPARE;
         code_a_reg <= bcr_pkg::RST_CODE_A;
         code_b_reg <= bcr_pkg::RST_CODE_B;
      end else begin
         if (wr_a || wr_b) begin
            regulator_enable_reg <= enable_next; // [RL2]
         end
         if (wr_a) begin
            spare_a_reg <= reg_wdata[bcr_pkg::SPARE_BIT];
            code_a_reg <= reg_wdata[5:0]; // [RL4]
         end
         if (wr_b) begin
            spare_b_reg <= reg_wdata[bcr_pkg::SPARE_BIT];
            code_b_reg <= reg_wdata[5:0]; // [RL4]
         end
      end
   end

   // ----------------------------------------
   // Configuration and control registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_bit5_reg <= bcr_pkg::RST_CFG_BIT5;
         pin_select_ctl_reg <= bcr_pkg::RST_PIN_SELECT;
         mode_reg <= bcr_pkg::RST_MODE;
         reg_b_pfm_reg <= bcr_pkg::RST_REG_B_PFM;
         low_pick_pfm_reg <= bcr_pkg::RST_LOW_PICK_PFM;
         off_pulldown_reg <= bcr_pkg::RST_PULLDOWN;
         ctl_spare_reg <= bcr_pkg::RST_CTL_SPARE;
         rise_slew_reg <= bcr_pkg::RST_SLEW;
      end else if (wr_cfg) begin
         cfg_bit5_reg <= reg_wdata[5];
         pin_select_ctl_reg <= reg_wdata[bcr_pkg::PIN_SELECT_BIT];
         mode_reg <= reg_wdata[bcr_pkg::MODE_LSB +: 2];
         reg_b_pfm_reg <= reg_wdata[bcr_pkg::REG_B_PFM_BIT];
         low_pick_pfm_reg <= reg_wdata[bcr_pkg::LOW_PICK_PFM_BIT]; // [RL22]
      end else if (wr_ctl) begin
         off_pulldown_reg <= reg_wdata[bcr_pkg::PULLDOWN_BIT];
         ctl_spare_reg <= reg_wdata[4:3];
         rise_slew_reg <= reg_wdata[2:0];
      end
   end

   // ----------------------------------------
   // Trigger, read data and converter outputs
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trigger_reg <= 1'b0;
         rdata_reg <= 8'h00;
         run_reg <= 1'b0;
         target_reg <= 6'h00;
         pfm_reg <= 1'b0;
         pulldown_out_reg <= 1'b0;
         start_reg <= 1'b0;
      end else if (ce) begin
         trigger_reg <= trigger_next;
         rdata_reg <= rd_mux;
         run_reg <= running;
         target_reg <= use_b ? code_b_reg : code_a_reg; // [RL6] [RL7] [RL8]
         pfm_reg <= pfm_next;
         pulldown_out_reg <= off_pulldown_reg && !running; // [RL17]
         start_reg <= trigger_accept; // [RL14]
      end
   end

   assign reg_rdata = rdata_reg;
   assign run = run_reg;
   assign target_code = target_reg;
   assign pfm_allowed = pfm_reg;
   assign off_pulldown = pulldown_out_reg;
   assign rise_slew_code = rise_slew_reg; // [RL19]
   assign single_step = (rise_slew_reg == bcr_pkg::SLEW_SINGLE_STEP); // [RL20]
   assign transition_start = start_reg;
endmodule
